// >>> optical_params.svh
// numeric constants for the optical port pin configuration block
`ifndef OPTICAL_PARAMS_SVH
`define OPTICAL_PARAMS_SVH

// register bus geometry
`define REG_ADDR_W        16
`define REG_DATA_W        8

// register byte addresses
`define TXCFG_ADDR        16'h2456
`define RXCFG_ADDR        16'h2457
`define SEGMAP_ADDR       16'h2458
`define STATUS_ADDR       16'h2459
`define PULSECFG_ADDR     16'h210C

// transmit configuration fields
`define TXCFG_INV_BIT     0
`define TXCFG_MOD_BIT     1
`define TXCFG_SRC_LSB     2
`define TXCFG_SRC_MSB     3

// receive configuration fields
`define RXCFG_BB_BIT      0
`define RXCFG_INV_BIT     1
`define RXCFG_DIS_BIT     2
`define RXCFG_DUTY_LSB    4
`define RXCFG_DUTY_MSB    5

// other fields: single bits and the two-bit status receive select
`define PULSE_INV_BIT     0
`define SEGMAP_TX_BIT     0
`define SEGMAP_RX_BIT     1
`define STAT_TX_BIT       0
`define STAT_TX_OE_BIT    1
`define STAT_RX_BIT       2
`define STAT_CARRIER_BIT  3
`define STAT_RXSEL_LSB    4
`define STAT_RXSEL_MSB    5

// field reset values
`define CFG_RESET         8'h00
`define FIELD2_RESET      2'h0

// carrier timing
`define CLK_HZ            100000000
`define CARRIER_HZ        38000
`define CARRIER_CYC       (`CLK_HZ / `CARRIER_HZ)
`define CARRIER_CNT_W     12

// synchroniser depth for pin inputs
`define SYNC_STAGES       2

`endif

// >>> optical_pkg.sv
// shared types for the optical port pin configuration block
package optical_pkg;

  typedef enum logic [1:0] {
    SRC_GPIO,
    SRC_UART,
    SRC_WATT,
    SRC_VAR
  } tx_src_t;

  typedef enum logic [1:0] {
    DUTY_HALF,
    DUTY_QUARTER,
    DUTY_EIGHTH,
    DUTY_SIXTEENTH
  } duty_t;

  typedef enum logic [1:0] {
    RX_UART,
    RX_GPIO,
    RX_SEG
  } rx_mode_t;

endpackage

// >>> carrier_if.sv
// carrier request and waveform between the port logic and its generator
`timescale 1ns/1ps
interface carrier_if;
  logic                 enable;
  optical_pkg::duty_t   duty;
  logic                 carrier;

  modport gen (
    input  enable,
    input  duty,
    output carrier
  );

  modport user (
    output enable,
    output duty,
    input  carrier
  );
endinterface

// >>> pin_sync.sv
// two-stage synchroniser for each pin input bit
`timescale 1ns/1ps
`include "optical_params.svh"
module pin_sync #(
  parameter int W = 2
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         ce_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      logic [`SYNC_STAGES-1:0] stage_r;
      // only the last stage is ever read outside this loop
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          stage_r <= '0;
        end else if (ce_i) begin
          stage_r <= {stage_r[`SYNC_STAGES-2:0], async_i[g]};
        end
      end
      assign sync_o[g] = stage_r[`SYNC_STAGES-1];
    end
  endgenerate

endmodule

// >>> carrier_gen.sv
// carrier generator with selectable low-time fraction
`timescale 1ns/1ps
`include "optical_params.svh"
module carrier_gen (
  input  wire logic mclk_i,
  input  wire logic reset_i,
  input  wire logic ce_i,
  carrier_if.gen    cif
);

  localparam logic [`CARRIER_CNT_W-1:0] PERIOD =
    `CARRIER_CNT_W'(`CARRIER_CYC);

  logic [`CARRIER_CNT_W-1:0] cnt_r;
  logic [`CARRIER_CNT_W-1:0] low_cyc;
  logic                      carrier_r;

  always_comb begin
    case (cif.duty)
      optical_pkg::DUTY_HALF:    low_cyc = PERIOD >> 1;
      optical_pkg::DUTY_QUARTER: low_cyc = PERIOD >> 2;
      optical_pkg::DUTY_EIGHTH:  low_cyc = PERIOD >> 3;
      default:                   low_cyc = PERIOD >> 4;
    endcase
  end

  // counter idles at zero while modulation is off
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (ce_i) begin
      if (!cif.enable || cnt_r == PERIOD - 1'b1) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // low phase first, then high for the rest of the period
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      carrier_r <= 1'b1;
    end else if (ce_i) begin
      carrier_r <= !(cif.enable && cnt_r < low_cyc);
    end
  end

  assign cif.carrier = carrier_r;

endmodule

// >>> optical_port_pin_config.sv
// optical port pin configuration: transmit and receive pin muxing
`timescale 1ns/1ps
`include "optical_params.svh"
module optical_port_pin_config (
  // clock, reset, enable
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic                   ce_i,
  // register port
  input  wire logic [`REG_ADDR_W-1:0] addr_i,
  input  wire logic [`REG_DATA_W-1:0] wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [`REG_DATA_W-1:0] rdata_o,
  // transmit sources from on-chip logic
  input  wire logic                   uart_tx_i,
  input  wire logic                   watt_hour_pulse_i,
  input  wire logic                   var_hour_pulse_i,
  input  wire logic                   general_io_tx_out_i,
  input  wire logic                   general_io_tx_dir_i,
  input  wire logic                   segment_driver_tx_i,
  // receive-side on-chip signals
  input  wire logic                   general_io_rx_out_i,
  input  wire logic                   general_io_rx_dir_i,
  input  wire logic                   segment_driver_rx_i,
  // infrared transmit pin
  input  wire logic                   infrared_transmit_pin_i,
  output logic                        infrared_transmit_pin_o,
  output logic                        infrared_transmit_pin_oe_o,
  // infrared receive pin (comparator result)
  input  wire logic                   infrared_receive_pin_i,
  output logic                        infrared_receive_pin_o,
  output logic                        infrared_receive_pin_oe_o,
  // inputs returned to on-chip logic
  output logic                        uart_rx_o,
  output logic                        general_io_tx_in_o,
  output logic                        general_io_rx_in_o,
  output logic                        bitbang_uart_io_o
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  logic                   tx_invert_r;
  logic                   tx_mod_en_r;
  optical_pkg::tx_src_t   tx_src_r;
  logic                   rx_bitbang_r;
  logic                   rx_invert_r;
  logic                   rx_disable_r;
  optical_pkg::duty_t     duty_r;
  logic                   pulse_inv_r;
  logic                   segmap_tx_r;
  logic                   segmap_rx_r;

  logic                   wr_tx;
  logic                   wr_rx;
  logic                   wr_pulse;
  logic                   wr_seg;

  assign wr_tx    = wr_i && addr_i == `TXCFG_ADDR;
  assign wr_rx    = wr_i && addr_i == `RXCFG_ADDR;
  assign wr_pulse = wr_i && addr_i == `PULSECFG_ADDR;
  assign wr_seg   = wr_i && addr_i == `SEGMAP_ADDR;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_invert_r <= 1'b0;
      tx_mod_en_r <= 1'b0;
      tx_src_r    <= optical_pkg::SRC_GPIO;
    end else if (ce_i && wr_tx) begin
      tx_invert_r <= wdata_i[`TXCFG_INV_BIT];
      tx_mod_en_r <= wdata_i[`TXCFG_MOD_BIT];
      tx_src_r    <= optical_pkg::tx_src_t'(
                       wdata_i[`TXCFG_SRC_MSB:`TXCFG_SRC_LSB]);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rx_bitbang_r <= 1'b0;
      rx_invert_r  <= 1'b0;
      rx_disable_r <= 1'b0;
      duty_r       <= optical_pkg::DUTY_HALF;
    end else if (ce_i && wr_rx) begin
      rx_bitbang_r <= wdata_i[`RXCFG_BB_BIT];
      rx_invert_r  <= wdata_i[`RXCFG_INV_BIT];
      rx_disable_r <= wdata_i[`RXCFG_DIS_BIT];
      duty_r       <= optical_pkg::duty_t'(
                        wdata_i[`RXCFG_DUTY_MSB:`RXCFG_DUTY_LSB]);
    end
  end

  // pulse polarity and segment map bits
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pulse_inv_r <= 1'b0;
    end else if (ce_i && wr_pulse) begin
      pulse_inv_r <= wdata_i[`PULSE_INV_BIT];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      segmap_tx_r <= 1'b0;
      segmap_rx_r <= 1'b0;
    end else if (ce_i && wr_seg) begin
      segmap_tx_r <= wdata_i[`SEGMAP_TX_BIT];
      segmap_rx_r <= wdata_i[`SEGMAP_RX_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  logic [1:0] pin_sync_w;
  logic       tx_pin_sync;
  logic       rx_pin_sync;

  pin_sync #(
    .W (2)
  ) u_pin_sync (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .async_i ({infrared_receive_pin_i, infrared_transmit_pin_i}),
    .sync_o  (pin_sync_w)
  );

  assign tx_pin_sync = pin_sync_w[0];
  assign rx_pin_sync = pin_sync_w[1];

  ////////////////////////////////////////////////////////////////////////////
  // carrier

  carrier_if cif ();

  assign cif.enable = tx_mod_en_r;
  assign cif.duty   = duty_r;

  carrier_gen u_carrier_gen (
    .mclk_i  (mclk_i),
    .reset_i (reset_i),
    .ce_i    (ce_i),
    .cif     (cif)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transmit path

  logic uart_inv;
  logic uart_mod;
  logic watt_lvl;
  logic var_lvl;
  logic tx_nxt;
  logic tx_oe_nxt;

  assign uart_inv = uart_tx_i ^ tx_invert_r;

  assign uart_mod = (tx_mod_en_r && !uart_inv) ? cif.carrier : uart_inv;

  assign watt_lvl = pulse_inv_r ? watt_hour_pulse_i : !watt_hour_pulse_i;
  assign var_lvl  = pulse_inv_r ? var_hour_pulse_i  : !var_hour_pulse_i;

  always_comb begin
    tx_nxt    = 1'b0;
    tx_oe_nxt = 1'b0;
    if (segmap_tx_r) begin
      tx_nxt    = segment_driver_tx_i;
      tx_oe_nxt = 1'b1;
    end else begin
      case (tx_src_r)
        optical_pkg::SRC_GPIO: begin
          tx_nxt    = general_io_tx_out_i;
          tx_oe_nxt = general_io_tx_dir_i;
        end
        optical_pkg::SRC_UART: begin
          tx_nxt    = uart_mod;
          tx_oe_nxt = 1'b1;
        end
        optical_pkg::SRC_WATT: begin
          tx_nxt    = watt_lvl;
          tx_oe_nxt = 1'b1;
        end
        optical_pkg::SRC_VAR: begin
          tx_nxt    = var_lvl;
          tx_oe_nxt = 1'b1;
        end
        default: begin
          tx_nxt    = 1'b0;
          tx_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  // registered pin drive keeps glitches of the mux off the led
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      infrared_transmit_pin_o    <= 1'b0;
      infrared_transmit_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      infrared_transmit_pin_o    <= tx_nxt;
      infrared_transmit_pin_oe_o <= tx_oe_nxt;
    end
  end

  // general io input of the transmit pin, only while it is general io
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      general_io_tx_in_o <= 1'b0;
    end else if (ce_i) begin
      general_io_tx_in_o <= !segmap_tx_r &&
                            tx_src_r == optical_pkg::SRC_GPIO &&
                            tx_pin_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path

  optical_pkg::rx_mode_t rx_mode;

  always_comb begin
    if (segmap_rx_r) begin
      rx_mode = optical_pkg::RX_SEG;
    end else if (rx_disable_r) begin
      rx_mode = optical_pkg::RX_GPIO;
    end else begin
      rx_mode = optical_pkg::RX_UART;
    end
  end

  // uart idles high whenever the pin is not its input
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      uart_rx_o <= 1'b1;
    end else if (ce_i) begin
      if (rx_mode == optical_pkg::RX_UART) begin
        uart_rx_o <= rx_pin_sync ^ rx_invert_r;
      end else begin
        uart_rx_o <= 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      general_io_rx_in_o <= 1'b0;
    end else if (ce_i) begin
      general_io_rx_in_o <= rx_mode == optical_pkg::RX_GPIO && rx_pin_sync;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      bitbang_uart_io_o <= 1'b0;
    end else if (ce_i) begin
      bitbang_uart_io_o <= rx_bitbang_r && rx_pin_sync;
    end
  end

  // receive pin drive: only as segment or as general io output
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      infrared_receive_pin_o    <= 1'b0;
      infrared_receive_pin_oe_o <= 1'b0;
    end else if (ce_i) begin
      case (rx_mode)
        optical_pkg::RX_SEG: begin
          infrared_receive_pin_o    <= segment_driver_rx_i;
          infrared_receive_pin_oe_o <= 1'b1;
        end
        optical_pkg::RX_GPIO: begin
          infrared_receive_pin_o    <= general_io_rx_out_i;
          infrared_receive_pin_oe_o <= general_io_rx_dir_i;
        end
        default: begin
          infrared_receive_pin_o    <= 1'b0;
          infrared_receive_pin_oe_o <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read

  logic [`REG_DATA_W-1:0] rd_nxt;

  always_comb begin
    rd_nxt = `CFG_RESET;
    case (addr_i)
      `TXCFG_ADDR: begin
        rd_nxt[`TXCFG_INV_BIT] = tx_invert_r;
        rd_nxt[`TXCFG_MOD_BIT] = tx_mod_en_r;
        rd_nxt[`TXCFG_SRC_MSB:`TXCFG_SRC_LSB] = tx_src_r;
      end
      `RXCFG_ADDR: begin
        rd_nxt[`RXCFG_BB_BIT]  = rx_bitbang_r;
        rd_nxt[`RXCFG_INV_BIT] = rx_invert_r;
        rd_nxt[`RXCFG_DIS_BIT] = rx_disable_r;
        rd_nxt[`RXCFG_DUTY_MSB:`RXCFG_DUTY_LSB] = duty_r;
      end
      `PULSECFG_ADDR: begin
        rd_nxt[`PULSE_INV_BIT] = pulse_inv_r;
      end
      `SEGMAP_ADDR: begin
        rd_nxt[`SEGMAP_TX_BIT] = segmap_tx_r;
        rd_nxt[`SEGMAP_RX_BIT] = segmap_rx_r;
      end
      `STATUS_ADDR: begin
        rd_nxt[`STAT_TX_BIT]      = infrared_transmit_pin_o;
        rd_nxt[`STAT_TX_OE_BIT]   = infrared_transmit_pin_oe_o;
        rd_nxt[`STAT_RX_BIT]      = rx_pin_sync;
        rd_nxt[`STAT_CARRIER_BIT] = cif.carrier;
        rd_nxt[`STAT_RXSEL_MSB:`STAT_RXSEL_LSB] = rx_mode;
      end
      default: begin
        rd_nxt = `CFG_RESET;
      end
    endcase
  end

  // data stands one cycle only, zero otherwise and for unmapped addresses
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_o <= `CFG_RESET;
    end else if (ce_i) begin
      rdata_o <= rd_i ? rd_nxt : `CFG_RESET;
    end
  end

endmodule

// >>> optical_port_pin_config_properties.sv
// assertions on the optical port pin configuration ports
`timescale 1ns/1ps
`include "optical_params.svh"
module optical_port_pin_config_properties (
  // clock, reset, enable
  input wire logic        mclk_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  // register port
  input wire logic [15:0] addr_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  rdata_o,
  // transmit sources
  input wire logic        uart_tx_i,
  input wire logic        watt_hour_pulse_i,
  input wire logic        var_hour_pulse_i,
  input wire logic        general_io_tx_out_i,
  input wire logic        general_io_tx_dir_i,
  input wire logic        segment_driver_tx_i,
  // pins and returned inputs
  input wire logic        infrared_receive_pin_i,
  input wire logic        infrared_transmit_pin_o,
  input wire logic        infrared_transmit_pin_oe_o,
  input wire logic        infrared_receive_pin_oe_o,
  input wire logic        uart_rx_o,
  input wire logic        general_io_rx_in_o,
  input wire logic        bitbang_uart_io_o
);
  logic [7:0] tx_r, rx_r, seg_r, pls_r;
  logic [2:0] run_r;
  wire        q      = run_r == 3'h4;
  wire        gpio_s = !seg_r[0] && tx_r[3:2] == 2'h0;
  wire        uart_s = !seg_r[0] && tx_r[3:2] == 2'h1;
  wire        pls_s  = !seg_r[0] && tx_r[3];
  wire        seg_tx = seg_r[0];
  wire        seg_rx = seg_r[1];
  wire        mod_on = tx_r[1];
  wire        u_lvl  = uart_tx_i ^ tx_r[0];
  wire        p_raw  = tx_r[2] ? var_hour_pulse_i : watt_hour_pulse_i;
  wire        p_lvl  = p_raw ^ !pls_r[0];
  wire        rx_u   = !seg_r[1] && !rx_r[2];
  wire        rx_g   = !seg_r[1] && rx_r[2];
  wire        rx_inv = rx_r[1];
  wire        bb     = rx_r[0];
  wire        rd_tx  = ce_i && rd_i && addr_i == `TXCFG_ADDR;

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);

  ////////////////////////////////////////////////////////////////////////////
  // shadow of what software wrote, reserved bits dropped
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      tx_r  <= 8'h00;
      rx_r  <= 8'h00;
      seg_r <= 8'h00;
      pls_r <= 8'h00;
    end else if (ce_i && wr_i) begin
      case (addr_i)
        `TXCFG_ADDR:    tx_r  <= wdata_i & 8'h0F;
        `RXCFG_ADDR:    rx_r  <= wdata_i & 8'h37;
        `SEGMAP_ADDR:   seg_r <= wdata_i & 8'h03;
        `PULSECFG_ADDR: pls_r <= wdata_i & 8'h01;
        default: ;
      endcase
    end
  end

  // pipeline history is only trusted after four live edges
  always_ff @(posedge mclk_i) begin
    if (reset_i || !ce_i) begin
      run_r <= 3'h0;
    end else if (!q) begin
      run_r <= run_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_tx_gpio_route: assert property (
    q && $past(gpio_s) |-> infrared_transmit_pin_o == $past(general_io_tx_out_i)
      && infrared_transmit_pin_oe_o == $past(general_io_tx_dir_i))
    else $error("tx pin does not follow gpio");
  a_tx_seg_override: assert property (
    q && $past(seg_tx) |-> infrared_transmit_pin_oe_o
      && infrared_transmit_pin_o == $past(segment_driver_tx_i))
    else $error("tx pin not driven by segment");
  a_tx_invert_plain: assert property (
    q && $past(uart_s) && !$past(mod_on) |->
      infrared_transmit_pin_o == $past(u_lvl))
    else $error("tx pin not uart after invert");
  a_tx_mod_high: assert property (
    q && $past(uart_s) && $past(mod_on) && $past(u_lvl) |->
      infrared_transmit_pin_o)
    else $error("carrier applied to a high level");
  a_pulse_level: assert property (
    q && $past(pls_s) |-> infrared_transmit_pin_o == $past(p_lvl))
    else $error("energy pulse polarity wrong");
  a_rx_uart_path: assert property (
    q && $past(rx_u) |->
      uart_rx_o == ($past(infrared_receive_pin_i, 3) ^ $past(rx_inv)))
    else $error("uart input not the receive pin");
  a_rx_gpio_plain: assert property (
    q && $past(rx_g) |-> uart_rx_o
      && general_io_rx_in_o == $past(infrared_receive_pin_i, 3))
    else $error("gpio input on receive pin wrong");
  a_rx_seg_idle: assert property (
    q && $past(seg_rx) |-> uart_rx_o && infrared_receive_pin_oe_o)
    else $error("receive pin not a segment");
  a_bitbang_copy: assert property (
    q |-> bitbang_uart_io_o
      == ($past(bb) && $past(infrared_receive_pin_i, 3)))
    else $error("bitbang io not the receive pin");
  a_tx_readback: assert property (
    q && $past(rd_tx) |-> rdata_o == $past(tx_r))
    else $error("transmit config reads back wrong");
endmodule

bind optical_port_pin_config optical_port_pin_config_properties u_props (
  .mclk_i, .reset_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
  .uart_tx_i, .watt_hour_pulse_i, .var_hour_pulse_i, .general_io_tx_out_i,
  .general_io_tx_dir_i, .segment_driver_tx_i, .infrared_receive_pin_i,
  .infrared_transmit_pin_o, .infrared_transmit_pin_oe_o,
  .infrared_receive_pin_oe_o, .uart_rx_o, .general_io_rx_in_o,
  .bitbang_uart_io_o
);

// >>> optical_receiver_model.sv
// receiver comparator standing on the infrared receive pin
`timescale 1ns/1ps
module optical_receiver_model (
  // light reaching the photo diode
  input  wire logic light_i,
  // design side of the receive pin
  input  wire logic rx_drv_i,
  input  wire logic rx_oe_i,
  // resolved pin level
  output logic      rx_wire_o
);
  // the design wins whenever it drives the pin as a segment or gpio
  assign rx_wire_o = rx_oe_i ? rx_drv_i : light_i;
endmodule

// >>> optical_port_pin_config_tb_top.sv
// self-checking bench for the optical port pin configuration block
`timescale 1ns/1ps
`include "optical_params.svh"
module optical_port_pin_config_tb_top;
  logic        mclk_i, reset_i, ce_i, wr_i, rd_i, light;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i, rdata_o, rd_v;
  logic        uart_tx_i, watt_hour_pulse_i, var_hour_pulse_i;
  logic        general_io_tx_out_i, general_io_tx_dir_i;
  logic        segment_driver_tx_i, segment_driver_rx_i;
  logic        general_io_rx_out_i, general_io_rx_dir_i;
  logic        infrared_transmit_pin_i, infrared_transmit_pin_o;
  logic        infrared_transmit_pin_oe_o, infrared_receive_pin_i;
  logic        infrared_receive_pin_o, infrared_receive_pin_oe_o;
  logic        uart_rx_o, general_io_tx_in_o, general_io_rx_in_o;
  logic        bitbang_uart_io_o;
  int          error_cnt, n_checks;

  optical_port_pin_config dut (
    .mclk_i, .reset_i, .ce_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .uart_tx_i, .watt_hour_pulse_i, .var_hour_pulse_i,
    .general_io_tx_out_i, .general_io_tx_dir_i, .segment_driver_tx_i,
    .general_io_rx_out_i, .general_io_rx_dir_i, .segment_driver_rx_i,
    .infrared_transmit_pin_i, .infrared_transmit_pin_o,
    .infrared_transmit_pin_oe_o, .infrared_receive_pin_i,
    .infrared_receive_pin_o, .infrared_receive_pin_oe_o, .uart_rx_o,
    .general_io_tx_in_o, .general_io_rx_in_o, .bitbang_uart_io_o
  );
  optical_receiver_model rx_front (
    .light_i   (light),
    .rx_drv_i  (infrared_receive_pin_o),
    .rx_oe_i   (infrared_receive_pin_oe_o),
    .rx_wire_o (infrared_receive_pin_i)
  );
  // led series resistor pulls the released pin high
  assign infrared_transmit_pin_i =
    infrared_transmit_pin_oe_o ? infrared_transmit_pin_o : 1'b1;

  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] e,
                     input logic [11:0] got);
    n_checks++;
    if (got !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", what, e, got);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic do_reset;
    @(posedge mclk_i);
    reset_i <= 1'b1;
    @(posedge mclk_i);
    reset_i <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge mclk_i);
    wr_i    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge mclk_i);
    rd_i   <= 1'b0;
    #1 rd_v = rdata_o;
  endtask
  // one carrier period holds the same count of low cycles whatever the phase
  task automatic count_low(output int lows);
    lows = 0;
    repeat (`CARRIER_CYC) begin
      tick(1);
      lows += (infrared_transmit_pin_o === 1'b0);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [15:0] a [5];
    logic [7:0]  m [5];
    a = '{`TXCFG_ADDR, `RXCFG_ADDR, `SEGMAP_ADDR, `PULSECFG_ADDR, 16'h1234};
    m = '{8'h0F, 8'h37, 8'h03, 8'h01, 8'h00};
    foreach (a[i]) begin
      rd(a[i]);
      chk("reset value", 8'h00, rd_v);
      wr(a[i], 8'hFF);
      rd(a[i]);
      chk("register bits", m[i], rd_v);
    end
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(`TXCFG_ADDR, 8'h00);
    @(posedge mclk_i);
    ce_i <= 1'b1;
    rd(`TXCFG_ADDR);
    chk("frozen write", 8'h0F, rd_v);
    do_reset();
    rd(`RXCFG_ADDR);
    chk("cleared by reset", 8'h00, rd_v);
    rd(`STATUS_ADDR);
    chk("status after reset", 8'h0F, rd_v);
    $display("register test done");
  endtask

  task automatic t_tx_src;
    logic e;
    logic np;
    for (int p = 0; p < 2; p++) begin
      do_reset();
      wr(`PULSECFG_ADDR, 8'(p));
      np = (p == 0);
      for (int s = 0; s < 5; s++) begin
        wr(`SEGMAP_ADDR, {7'h00, s == 4});
        wr(`TXCFG_ADDR, {4'h0, 2'(s), 2'h0});
        for (int b = 0; b < 2; b++) begin
          // unselected sources would all show the opposite level
          e = b[0] ^ ((s == 2 || s == 3) && np);
          @(posedge mclk_i);
          general_io_tx_out_i <= s == 0 ? b[0] : !e;
          uart_tx_i           <= s == 1 ? b[0] : !e;
          watt_hour_pulse_i   <= s == 2 ? b[0] : !e ^ np;
          var_hour_pulse_i    <= s == 3 ? b[0] : !e ^ np;
          segment_driver_tx_i <= s == 4 ? b[0] : !e;
          tick(2);
          chk("tx pin", e, infrared_transmit_pin_o);
          tick(2);
          chk("gpio tx in", (s == 0) & e, general_io_tx_in_o);
        end
      end
    end
    $display("tx source test done");
  endtask

  task automatic t_tx_mod;
    int lows;
    do_reset();
    wr(`TXCFG_ADDR, 8'h05);
    for (int b = 0; b < 2; b++) begin
      @(posedge mclk_i);
      uart_tx_i <= b[0];
      tick(2);
      chk("inverted tx", !b[0], infrared_transmit_pin_o);
    end
    wr(`TXCFG_ADDR, 8'h07);
    for (int d = 0; d < 4; d++) begin
      wr(`RXCFG_ADDR, {2'h0, 2'(d), 4'h0});
      tick(`CARRIER_CYC + 8);
      count_low(lows);
      chk("low time", 12'(`CARRIER_CYC >> (d + 1)), 12'(lows));
    end
    @(posedge mclk_i);
    uart_tx_i <= 1'b0;
    tick(4);
    count_low(lows);
    chk("steady high", 12'h000, 12'(lows));
    $display("modulation test done");
  endtask

  task automatic t_rx;
    logic [7:0] cfg [4];
    logic [1:0] seg_v;
    cfg = '{8'h00, 8'h02, 8'h06, 8'h01};
    do_reset();
    foreach (cfg[c]) begin
      wr(`RXCFG_ADDR, cfg[c]);
      for (int b = 0; b < 2; b++) begin
        @(posedge mclk_i);
        light <= b[0];
        tick(4);
        chk("uart rx", cfg[c][2] | (b[0] ^ cfg[c][1]), uart_rx_o);
        chk("gpio rx in", cfg[c][2] & b[0], general_io_rx_in_o);
        chk("bitbang io", cfg[c][0] & b[0], bitbang_uart_io_o);
      end
    end
    wr(`RXCFG_ADDR, 8'h04);
    @(posedge mclk_i);
    general_io_rx_dir_i <= 1'b1;
    tick(2);
    seg_v = {infrared_receive_pin_oe_o, infrared_receive_pin_o};
    chk("rx gpio drive", 2'h2, seg_v);
    wr(`SEGMAP_ADDR, 8'h02);
    @(posedge mclk_i);
    segment_driver_rx_i <= 1'b1;
    tick(2);
    seg_v = {infrared_receive_pin_oe_o, infrared_receive_pin_o};
    chk("rx segment drive", 2'h3, seg_v);
    chk("uart idle", 1'b1, uart_rx_o);
    $display("receive test done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    ce_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    uart_tx_i = 1'b1;
    watt_hour_pulse_i = 1'b0;
    var_hour_pulse_i = 1'b0;
    general_io_tx_out_i = 1'b1;
    general_io_tx_dir_i = 1'b1;
    segment_driver_tx_i = 1'b0;
    segment_driver_rx_i = 1'b0;
    general_io_rx_out_i = 1'b0;
    general_io_rx_dir_i = 1'b0;
    light = 1'b1;
    error_cnt = 0;
    n_checks = 0;
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    // receive synchroniser clears low, so uart input settles three edges later
    tick(4);
    chk("tx pin after reset", 1'b1, infrared_transmit_pin_o);
    chk("uart after reset", 1'b1, uart_rx_o);
    t_regs();
    t_tx_src();
    t_tx_mod();
    t_rx();
    conclude();
  end

  initial begin
    repeat (100000) @(posedge mclk_i);
    error_cnt++;
    $display("MISMATCH run length expected end seen timeout");
    conclude();
  end
endmodule
